// ### hw/relay_gate_pkg.sv
package relay_gate_pkg;
  // register map
  localparam logic [7:0] FaultStatusAddr = 8'h00;
  localparam logic [7:0] RelayFaultAddr = 8'h01;
  localparam logic [7:0] HighSideControlAddr = 8'h11;
  localparam logic [7:0] IgnoreControlAddr = 8'h12;
  // high_side_control fields
  localparam int GateEnableBit = 2;
  localparam int OvOffSelectBit = 5;
  // timing
  localparam int ClockPeriodNs = 5;
  localparam int OvercurrentDeglitchNs = 10000;
  localparam int GateShortCheckNs = 20000;
  localparam int LeakageCheckNs = 50000;
  localparam int OvercurrentDeglitchCycles = (OvercurrentDeglitchNs + ClockPeriodNs - 1) / ClockPeriodNs;
  localparam int GateShortCheckCycles = (GateShortCheckNs + ClockPeriodNs - 1) / ClockPeriodNs;
  localparam int LeakageCheckCycles = (LeakageCheckNs + ClockPeriodNs - 1) / ClockPeriodNs;
  localparam int CountWidth = 16;

  typedef enum logic [2:0] {GateOff, LeakCheck, ShortWait, GateOn, Locked} phase_type;

  typedef struct packed {
    logic rstPin;
    logic wdFault;
    logic uvVdd;
    logic uvBat;
    logic ovBat;
    logic srcAbove;
    logic gateLow;
    logic compTwo;
    logic compOne;
    logic ctrlPin;
  } sync_type;

  // fault_status bits 6..0
  typedef struct packed {
    logic summary;
    logic wdState;
    logic wdFault;
    logic extReset;
    logic por;
    logic uvBat;
    logic ovBat;
  } sys_flag_type;

  // relay_fault bits 4..0
  typedef struct packed {
    logic leak;
    logic lowConflict;
    logic srcShort;
    logic gateShort;
    logic overcurrent;
  } relay_flag_type;

  typedef struct packed {
    logic wdEnable;
    logic lowIgnore;
    logic srcIgnore;
    logic gateIgnore;
    logic ocIgnore;
  } ignore_type;

  typedef struct packed {
    sync_type sync1;
    sync_type sync2;
    phase_type phase;
    logic [CountWidth-1:0] timer;
    logic [CountWidth-1:0] ocCnt;
    logic [CountWidth-1:0] ssCnt;
    logic gate;
    logic leakCur;
    logic rstDrive;
    logic [1:0] rstRelease;
    logic gateEnable;
    logic ovOff;
    ignore_type ign;
    sys_flag_type sysFlags;
    relay_flag_type relayFlags;
    logic [7:0] rdData;
  } state_type;

  localparam sync_type SyncReset = '{rstPin: 1'b1, default: 1'b0};
  localparam sys_flag_type SysFlagReset = '{wdState: 1'b1, default: 1'b0};
  localparam state_type StateReset = '{sync1: SyncReset, sync2: SyncReset, phase: GateOff,
    sysFlags: SysFlagReset, default: '0};
endpackage

// ### hw/master_relay_gate_control.sv
`timescale 1ns/1ps
`default_nettype none
module master_relay_gate_control #(
  parameter int OcCycles = relay_gate_pkg::OvercurrentDeglitchCycles,
  parameter int ShortCycles = relay_gate_pkg::GateShortCheckCycles,
  parameter int LeakCycles = relay_gate_pkg::LeakageCheckCycles
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // relay pins and comparators
  input wire logic relayControlPin,
  input wire logic comparatorOneOut,
  input wire logic comparatorTwoOut,
  input wire logic gateLowSense,
  input wire logic sourceAboveSupply,
  output logic relayGateOut,
  output logic leakageTestCurrentEn,
  // supervisors and low-side state
  input wire logic batteryOvervoltage,
  input wire logic batteryUndervoltage,
  input wire logic supplyUndervoltage,
  input wire logic watchdogFaultIn,
  input wire logic [7:0] lowsideOn,
  // open-drain reset pin
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe
);
  localparam int CW = relay_gate_pkg::CountWidth;
  localparam logic [CW-1:0] OcLast = CW'(OcCycles - 1);
  localparam logic [CW-1:0] ShortLast = CW'(ShortCycles - 1);
  localparam logic [CW-1:0] LeakLast = CW'(LeakCycles - 1);

  relay_gate_pkg::state_type s_q;
  relay_gate_pkg::state_type s_d;
  relay_gate_pkg::sync_type live;
  logic lowAny, request, extLow, wdBlock, ovBlock, hardOff;
  logic ocRaw, ssRaw, ocHit, ssHit, rdStatus, rdRelay;
  logic evOc, evSs, evGs, evLc, evLeak;

  assign live = s_q.sync2;
  assign lowAny = |lowsideOn;
  // pin needs a pull-down so an open pin reads low
  assign request = live.ctrlPin | s_q.gateEnable;
  // our own release needs two edges to clear the synchroniser; no false external reset
  assign extLow = ~live.rstPin & ~s_q.rstDrive & ~|s_q.rstRelease;
  assign wdBlock = live.wdFault & s_q.ign.wdEnable;
  assign ovBlock = live.ovBat & s_q.ovOff;
  assign hardOff = live.uvVdd | live.uvBat | wdBlock | extLow | ovBlock;
  // comparator pattern decoding is left to software except for these two cases
  assign ocRaw = live.compOne & ~live.compTwo & lowAny & s_q.gate;
  assign ssRaw = live.compOne & live.compTwo & s_q.gate;
  assign ocHit = ocRaw && (s_q.ocCnt == OcLast);
  assign ssHit = ssRaw && (s_q.ssCnt == OcLast);
  assign rdStatus = regRead && (regAddr == relay_gate_pkg::FaultStatusAddr);
  assign rdRelay = regRead && (regAddr == relay_gate_pkg::RelayFaultAddr);

  always_comb begin
    s_d = s_q;
    evOc = 1'b0;
    evSs = 1'b0;
    evGs = 1'b0;
    evLc = 1'b0;
    evLeak = 1'b0;
    // raw pins see two stages before any decision
    s_d.sync1 = '{rstPin: resetPinIn, wdFault: watchdogFaultIn, uvVdd: supplyUndervoltage,
      uvBat: batteryUndervoltage, ovBat: batteryOvervoltage, srcAbove: sourceAboveSupply,
      gateLow: gateLowSense, compTwo: comparatorTwoOut, compOne: comparatorOneOut,
      ctrlPin: relayControlPin};
    s_d.sync2 = s_q.sync1;
    // deglitch counters saturate at the last count
    s_d.ocCnt = !ocRaw ? '0 : (ocHit ? s_q.ocCnt : s_q.ocCnt + 1'b1);
    s_d.ssCnt = !ssRaw ? '0 : (ssHit ? s_q.ssCnt : s_q.ssCnt + 1'b1);
    s_d.timer = s_q.timer + 1'b1;
    unique case (s_q.phase)
      relay_gate_pkg::GateOff: begin
        s_d.timer = '0;
        if (request && !hardOff) begin
          if (lowAny) begin
            evLc = 1'b1;
          end
          if (lowAny && !s_q.ign.lowIgnore) begin
            s_d.phase = relay_gate_pkg::Locked;
          end else begin
            s_d.phase = relay_gate_pkg::LeakCheck;
            s_d.leakCur = 1'b1;
          end
        end
      end
      relay_gate_pkg::LeakCheck: begin
        if (s_q.timer == LeakLast) begin
          s_d.leakCur = 1'b0;
          s_d.timer = '0;
          if (live.srcAbove) begin
            s_d.gate = 1'b1;
            s_d.phase = relay_gate_pkg::ShortWait;
          end else begin
            evLeak = 1'b1;
            s_d.phase = relay_gate_pkg::Locked;
          end
        end
      end
      relay_gate_pkg::ShortWait: begin
        // the gate slews during the wait, so a low gate is no fault yet
        if (s_q.timer == ShortLast) begin
          s_d.phase = relay_gate_pkg::GateOn;
          if (live.gateLow) begin
            evGs = 1'b1;
            if (!s_q.ign.gateIgnore) begin
              s_d.gate = 1'b0;
              s_d.phase = relay_gate_pkg::Locked;
            end
          end
        end
        // overcurrent and source short count as soon as the gate is on
        evOc = ocHit;
        evSs = ssHit;
        if ((ocHit && !s_q.ign.ocIgnore) || (ssHit && !s_q.ign.srcIgnore)) begin
          s_d.gate = 1'b0;
          s_d.phase = relay_gate_pkg::Locked;
        end
      end
      relay_gate_pkg::GateOn: begin
        s_d.timer = '0;
        evGs = live.gateLow;
        evOc = ocHit;
        evSs = ssHit;
        if ((live.gateLow && !s_q.ign.gateIgnore) || (ocHit && !s_q.ign.ocIgnore) ||
            (ssHit && !s_q.ign.srcIgnore)) begin
          s_d.gate = 1'b0;
          s_d.phase = relay_gate_pkg::Locked;
        end
      end
      relay_gate_pkg::Locked: begin
        s_d.timer = '0;
      end
    endcase
    // a tripped gate waits for the request to drop, or for a hard-off fault, before a new try
    if (!request || (hardOff && s_d.phase != relay_gate_pkg::Locked)) begin
      s_d.phase = request ? relay_gate_pkg::Locked : relay_gate_pkg::GateOff;
      s_d.gate = 1'b0;
      s_d.leakCur = 1'b0;
    end
    if (hardOff && request) begin
      s_d.phase = relay_gate_pkg::GateOff;
    end
    s_d.rstDrive = live.uvVdd;
    s_d.rstRelease = {s_q.rstRelease[0], s_q.rstDrive};
    // system flags: a new event wins over a read
    if (live.ovBat) begin
      s_d.sysFlags.ovBat = 1'b1;
    end else if (rdStatus) begin
      s_d.sysFlags.ovBat = 1'b0;
    end
    if (live.uvBat) begin
      s_d.sysFlags.uvBat = 1'b1;
    end else if (rdStatus) begin
      s_d.sysFlags.uvBat = 1'b0;
    end
    if (live.uvVdd) begin
      s_d.sysFlags.por = 1'b1;
    end else if (rdStatus) begin
      s_d.sysFlags.por = 1'b0;
    end
    if (extLow) begin
      s_d.sysFlags.extReset = 1'b1;
    end else if (rdStatus) begin
      s_d.sysFlags.extReset = 1'b0;
    end
    if (wdBlock) begin
      s_d.sysFlags.wdFault = 1'b1;
      s_d.sysFlags.wdState = 1'b0;
    end else if (rdStatus && !live.wdFault) begin
      s_d.sysFlags.wdFault = 1'b0;
      s_d.sysFlags.wdState = 1'b1;
    end
    if (evOc || evSs || evGs || evLc || evLeak) begin
      s_d.sysFlags.summary = 1'b1;
    end else if (rdRelay) begin
      s_d.sysFlags.summary = 1'b0;
    end
    // relay flags other than leak clear on read only once the cause is gone; leak clears on any read
    if (evOc) begin
      s_d.relayFlags.overcurrent = 1'b1;
    end else if (rdRelay && !ocRaw) begin
      s_d.relayFlags.overcurrent = 1'b0;
    end
    if (evGs) begin
      s_d.relayFlags.gateShort = 1'b1;
    end else if (rdRelay && !live.gateLow) begin
      s_d.relayFlags.gateShort = 1'b0;
    end
    if (evSs) begin
      s_d.relayFlags.srcShort = 1'b1;
    end else if (rdRelay && !ssRaw) begin
      s_d.relayFlags.srcShort = 1'b0;
    end
    if (evLc) begin
      s_d.relayFlags.lowConflict = 1'b1;
    end else if (rdRelay && !(lowAny && request)) begin
      s_d.relayFlags.lowConflict = 1'b0;
    end
    if (evLeak) begin
      s_d.relayFlags.leak = 1'b1;
    end else if (rdRelay) begin
      s_d.relayFlags.leak = 1'b0;
    end
    if (regWrite && regAddr == relay_gate_pkg::HighSideControlAddr) begin
      s_d.gateEnable = regWrData[relay_gate_pkg::GateEnableBit];
      s_d.ovOff = regWrData[relay_gate_pkg::OvOffSelectBit];
    end
    if (regWrite && regAddr == relay_gate_pkg::IgnoreControlAddr) begin
      s_d.ign = regWrData[4:0];
    end
    if (regRead) begin
      s_d.rdData = 8'h00;
      if (regAddr == relay_gate_pkg::FaultStatusAddr) begin
        s_d.rdData = {1'b0, s_q.sysFlags};
      end else if (regAddr == relay_gate_pkg::RelayFaultAddr) begin
        s_d.rdData = {1'b0, live.compTwo, live.compOne, s_q.relayFlags};
      end else if (regAddr == relay_gate_pkg::HighSideControlAddr) begin
        s_d.rdData[relay_gate_pkg::GateEnableBit] = s_q.gateEnable;
        s_d.rdData[relay_gate_pkg::OvOffSelectBit] = s_q.ovOff;
      end else if (regAddr == relay_gate_pkg::IgnoreControlAddr) begin
        s_d.rdData = {3'h0, s_q.ign};
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= relay_gate_pkg::StateReset;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign relayGateOut = s_q.gate;
  assign leakageTestCurrentEn = s_q.leakCur;
  assign resetPinOe = s_q.rstDrive;
  assign resetPinOut = 1'b0;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence leakEnd;
    s_q.phase == relay_gate_pkg::LeakCheck && s_q.timer == LeakLast;
  endsequence
  sequence shortEnd;
    s_q.phase == relay_gate_pkg::ShortWait && s_q.timer == ShortLast;
  endsequence

  a_gate_request: assert property (relayGateOut |-> $past(request))
    else $error("gate on without request");
  a_fault_off: assert property (hardOff |=> !relayGateOut)
    else $error("gate on during supply fault");
  a_oc_trip: assert property (ocHit && !s_q.ign.ocIgnore |=> !relayGateOut)
    else $error("overcurrent did not turn gate off");
  a_oc_flags: assert property (evOc |=> s_q.relayFlags.overcurrent && s_q.sysFlags.summary)
    else $error("overcurrent flags missing");
  a_leak_first: assert property ($rose(relayGateOut) |-> $past(leakageTestCurrentEn))
    else $error("gate rose without leakage check");
  a_leak_fault: assert property (leakEnd and !live.srcAbove and request and !hardOff
    |=> s_q.relayFlags.leak && !relayGateOut)
    else $error("leakage not flagged");
  a_short_hold: assert property (shortEnd and live.gateLow and !s_q.ign.gateIgnore
    |=> !relayGateOut && s_q.relayFlags.gateShort)
    else $error("gate short not held low");
  a_src_short: assert property (ssHit && !s_q.ign.srcIgnore
    |=> !relayGateOut && s_q.relayFlags.srcShort)
    else $error("source short not handled");
  a_lowside_lock: assert property (s_q.phase == relay_gate_pkg::GateOff && request && !hardOff
    && lowAny && !s_q.ign.lowIgnore |=> s_q.relayFlags.lowConflict ##1 !relayGateOut)
    else $error("low-side conflict not handled");
  a_por_reset: assert property (live.uvVdd |=> resetPinOe && s_q.sysFlags.por && !relayGateOut)
    else $error("undervoltage reset missing");
  a_watchdog_fault_bit: assert property (wdBlock |=> s_q.sysFlags.wdFault && !s_q.sysFlags.wdState)
    else $error("watchdog flags wrong");
  a_ext_reset: assert property (extLow |=> s_q.sysFlags.extReset && !relayGateOut)
    else $error("external reset not flagged");
  a_ov_off: assert property (live.ovBat && s_q.ovOff |=> !relayGateOut && s_q.sysFlags.ovBat)
    else $error("overvoltage off failed");
  a_ov_clear: assert property (rdStatus && !live.ovBat |=> !s_q.sysFlags.ovBat)
    else $error("overvoltage flag not cleared");
  a_comp_read: assert property (rdRelay |=> regRdData[6:5] == $past({live.compTwo, live.compOne}))
    else $error("comparator readback wrong");
endmodule
`default_nettype wire

// ### verification/relay_fet_model.sv
`timescale 1ns/1ps
`default_nettype none
module relay_fet_model (
  // drive from the gate controller, plus the low-side state
  input wire logic gate,
  input wire logic leakCur,
  input wire logic anyLowside,
  // faults the bench injects
  input wire logic leaky,
  input wire logic gateShort,
  input wire logic srcShort,
  input wire logic overload,
  // sensed levels
  output logic compOne,
  output logic compTwo,
  output logic gateLow,
  output logic srcAbove
);
  // source only climbs above supply while the test current flows
  assign srcAbove = leakCur & !leaky;
  assign gateLow = gate & gateShort;
  always_comb begin
    if (gate) begin
      compOne = overload | srcShort;
      compTwo = srcShort;
    end else begin
      compOne = 1'b1;
      compTwo = anyLowside;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, resetn, regWrite, regRead, relayControlPin, relayGateOut, leakageTestCurrentEn;
  logic [7:0] regAddr, regWrData, regRdData, lowsideOn;
  logic compOne, compTwo, gateLow, srcAbove, resetPinOut, resetPinOe, resetPin;
  logic ovBat, uvBat, uvVdd, wdIn, extLow, leaky, gateShort, srcShort, overload;
  int miscompares, checksDone, cycles;
  // open-drain reset line with pull-up
  assign resetPin = ((resetPinOe && !resetPinOut) || extLow) ? 1'b0 : 1'b1;

  master_relay_gate_control #(.OcCycles(4), .ShortCycles(4), .LeakCycles(4)) DUT (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .relayControlPin(relayControlPin), .comparatorOneOut(compOne),
    .comparatorTwoOut(compTwo), .gateLowSense(gateLow), .sourceAboveSupply(srcAbove),
    .relayGateOut(relayGateOut), .leakageTestCurrentEn(leakageTestCurrentEn),
    .batteryOvervoltage(ovBat), .batteryUndervoltage(uvBat),
    .supplyUndervoltage(uvVdd), .watchdogFaultIn(wdIn), .lowsideOn(lowsideOn),
    .resetPinIn(resetPin), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));

  relay_fet_model fet (.gate(relayGateOut), .leakCur(leakageTestCurrentEn),
    .anyLowside(|lowsideOn), .leaky(leaky), .gateShort(gateShort), .srcShort(srcShort),
    .overload(overload), .compOne(compOne), .compTwo(compTwo), .gateLow(gateLow),
    .srcAbove(srcAbove));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs about a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic regRd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    d = regRdData;
  endtask

  // bounded wait for the gate; notes whether the test current was seen
  task automatic waitGate(output logic [7:0] seenLeak);
    seenLeak = 8'h00;
    for (int i = 0; i < 40 && relayGateOut !== 1'b1; i++) begin
      @(posedge clock);
      #1;
      if (leakageTestCurrentEn === 1'b1) seenLeak = 8'h01;
    end
    // return on an edge so the caller's stimulus lands on it
    @(posedge clock);
  endtask

  task automatic pinOn();
    logic [7:0] s;
    relayControlPin <= 1'b1;
    waitGate(s);
    check({7'h0, relayGateOut}, 8'h01);
    check(s, 8'h01);
  endtask

  task automatic idle();
    logic [7:0] d;
    relayControlPin <= 1'b0;
    {leaky, gateShort, srcShort, overload, ovBat, uvBat, uvVdd, wdIn, extLow} <= '0;
    lowsideOn <= 8'h00;
    regWr(8'h11, 8'h00);
    repeat (10) @(posedge clock);
    regRd(8'h00, d);
    regRd(8'h01, d);
  endtask

  task automatic bitOnAndLeak();
    logic [7:0] d;
    regWr(8'h11, 8'h04);
    waitGate(d);
    check({7'h0, relayGateOut}, 8'h01);
    regRd(8'h11, d);
    check(d, 8'h04);
    idle();
    leaky <= 1'b1;
    relayControlPin <= 1'b1;
    waitGate(d);
    check({7'h0, relayGateOut}, 8'h00);
    regRd(8'h01, d);
    check(d, 8'h30);
    idle();
  endtask

  // k: 0 overcurrent, 1 gate short, 2 source short, 3 low-side conflict
  task automatic faultTrip(input int k, input logic ign);
    logic [7:0] d, live;
    logic lw;
    lw = (k == 0 || k == 3);
    regWr(8'h12, ign ? 8'h01 << k : 8'h00);
    gateShort <= (k == 1);
    lowsideOn <= (k == 3) ? 8'h80 : 8'h00;
    relayControlPin <= 1'b1;
    waitGate(d);
    lowsideOn <= lw ? 8'h80 : 8'h00;
    overload <= (k == 0);
    srcShort <= (k == 2);
    repeat (20) @(posedge clock);
    #1 check({7'h0, relayGateOut}, {7'h0, ign});
    live = ign ? {1'b0, k == 2, k == 0 || k == 2, 5'h0} : {1'b0, lw, 1'b1, 5'h0};
    regRd(8'h00, d);
    check(d, 8'h60);
    regRd(8'h01, d);
    check(d, (8'h01 << k) | live);
    idle();
  endtask

  task automatic overvoltage();
    logic [7:0] d;
    regWr(8'h11, 8'h04);
    waitGate(d);
    ovBat <= 1'b1;
    repeat (10) @(posedge clock);
    #1 check({7'h0, relayGateOut}, 8'h01);
    regRd(8'h00, d);
    check(d, 8'h21);
    regRd(8'h00, d);
    check(d, 8'h21);
    ovBat <= 1'b0;
    repeat (5) @(posedge clock);
    regRd(8'h00, d);
    check(d, 8'h21);
    regRd(8'h00, d);
    check(d, 8'h20);
    regWr(8'h11, 8'h24);
    ovBat <= 1'b1;
    repeat (10) @(posedge clock);
    #1 check({7'h0, relayGateOut}, 8'h00);
    idle();
  endtask

  // k: 0 battery undervoltage, 1 watchdog, 2 external reset, 3 supply undervoltage
  task automatic hardOff(input int k);
    logic [7:0] d;
    logic [7:0] exp[4] = '{8'h22, 8'h10, 8'h28, 8'h24};
    regWr(8'h12, (k == 1) ? 8'h10 : 8'h00);
    pinOn();
    uvBat <= (k == 0);
    wdIn <= (k == 1);
    extLow <= (k == 2);
    uvVdd <= (k == 3);
    repeat (10) @(posedge clock);
    #1 check({7'h0, relayGateOut}, 8'h00);
    check({7'h0, resetPinOe}, {7'h0, k == 3});
    regRd(8'h00, d);
    check(d, exp[k]);
    idle();
  endtask

  initial begin
    logic [7:0] d;
    {regAddr, regWrData, lowsideOn} = '0;
    {regWrite, regRead, relayControlPin, ovBat, uvBat, uvVdd, wdIn, extLow} = '0;
    {leaky, gateShort, srcShort, overload} = '0;
    {miscompares, checksDone, cycles} = '0;
    resetn = 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    regRd(8'h00, d);
    check(d, 8'h20);
    regRd(8'h11, d);
    check(d, 8'h00);
    regWr(8'h05, 8'hff);
    regRd(8'h05, d);
    check(d, 8'h00);
    pinOn();
    idle();
    bitOnAndLeak();
    for (int k = 0; k < 4; k++) begin
      faultTrip(k, 1'b0);
      faultTrip(k, 1'b1);
    end
    faultTrip(0, 1'b0);
    pinOn();
    idle();
    overvoltage();
    for (int k = 0; k < 4; k++) hardOff(k);
    summarize();
  end
endmodule
`default_nettype wire
